// ---- cmof_defs.vh ----
`ifndef CMOF_DEFS_VH
`define CMOF_DEFS_VH
// Global register byte offsets
`define CMOF_OFS_CTRL 8'h00
`define CMOF_OFS_STAT 8'h02
`define CMOF_OFS_INT 8'h04
`define CMOF_OFS_BTIME 8'h06
`define CMOF_OFS_GMS 8'h08
`define CMOF_OFS_GML_LO 8'h0a
`define CMOF_OFS_GML_HI 8'h0c
`define CMOF_OFS_LMASK_LO 8'h0e
// High word of the last-object mask sits in the spare word of object 15
`define CMOF_OFS_LMASK_HI 8'hfe
// Object word index inside a 16-byte object slot
`define CMOF_OW_CTRL 3'h0
`define CMOF_OW_ID_LO 3'h1
`define CMOF_OW_ID_HI 3'h2
`define CMOF_OW_DATA0 3'h3
`define CMOF_OW_DATA3 3'h6
// Control register bits
`define CMOF_CTRL_SETUP 0
`define CMOF_CTRL_CFG_CHANGE 6
`define CMOF_CTRL_RESET 16'h0001
// Object control word bits
`define CMOF_OC_VALID 0
`define CMOF_OC_DIR 1
`define CMOF_OC_LONG 2
`define CMOF_OC_AUTO 3
`define CMOF_OC_TXREQ 4
`define CMOF_OC_RXDONE 5
`define CMOF_OC_TXDONE 6
// Status register bits
`define CMOF_ST_PASSIVE 0
`define CMOF_ST_BUSOFF 1
`define CMOF_ST_WARN 2
`define CMOF_ST_JOINED 3
// Error and join thresholds
`define CMOF_WARN_LIMIT 9'h060
`define CMOF_PASSIVE_LIMIT 9'h080
`define CMOF_BUSOFF_LIMIT 10'h100
`define CMOF_IDLE_BITS 4'hb
// Number of the catch-all receive object
`define CMOF_LAST_OBJ 4'hf
`endif

// ---- cmof_mem.v ----
`default_nettype none
// Message data store, one 64-bit entry per object, registered read ports
module cmof_mem #(
  parameter DEPTH = 16
) (
  input wire i_clock,
  input wire i_rstn,
  input wire [3:0] i_wr_obj,
  input wire [3:0] i_wr_lanes,
  input wire [63:0] i_wr_data,
  input wire i_rd_en,
  input wire [3:0] i_rd_obj,
  input wire [1:0] i_rd_lane,
  input wire i_rd_use_mem,
  input wire [15:0] i_rd_bypass,
  output reg [15:0] o_rd_data,
  input wire i_tx_rd,
  input wire [3:0] i_tx_obj,
  output reg [63:0] o_tx_data
);
  reg [63:0] mem [0:DEPTH-1];
  wire [63:0] rd_word = mem[i_rd_obj];
  integer l;
  // Per-lane write, 16 bits each, one process so the array has one driver
  always @(posedge i_clock) begin
    for (l = 0; l < 4; l = l + 1) begin
      if (i_wr_lanes[l]) begin
        mem[i_wr_obj][16*l +: 16] <= i_wr_data[16*l +: 16];
      end
    end
  end
  // Bus read port: memory word or register value from the top
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_en) begin
      if (i_rd_use_mem) begin
        case (i_rd_lane)
          2'h0: o_rd_data <= rd_word[15:0];
          2'h1: o_rd_data <= rd_word[31:16];
          2'h2: o_rd_data <= rd_word[47:32];
          default: o_rd_data <= rd_word[63:48];
        endcase
      end else begin
        o_rd_data <= i_rd_bypass;
      end
    end
  end
  // Transmit fetch port
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_data <= 64'h0;
    end else if (i_tx_rd) begin
      o_tx_data <= mem[i_tx_obj];
    end
  end
endmodule
`default_nettype wire

// ---- cmof_btl.v ----
`default_nettype none
// Bit timing: pin synchroniser, quantum divider, sample point, sync
module cmof_btl (
  input wire i_clock,
  input wire i_rstn,
  input wire i_can_rx,
  input wire [5:0] i_brp,
  input wire [3:0] i_tseg1,
  input wire [2:0] i_tseg2,
  input wire [1:0] i_sjw,
  input wire i_bus_idle,
  input wire i_tx_dominant,
  output reg o_rx_bit,
  output reg o_sample
);
  reg s1_q, s2_q, prev_q;
  reg [5:0] pre_q;
  reg [4:0] tq_q, ext_q;
  wire tq_en = (pre_q == i_brp);
  wire fall = prev_q & ~s2_q;
  wire [4:0] s_pt = {1'b0, i_tseg1} + 5'h01 + ext_q;
  wire [4:0] e_pt = s_pt + {2'h0, i_tseg2} + 5'h01;
  wire [4:0] sjw_len = {3'h0, i_sjw} + 5'h01;
  wire [4:0] left = e_pt - tq_q;
  // Two-flop synchroniser, then an edge history flop
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      s1_q <= i_can_rx;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end
  // Quantum counting with hard sync and resync on falling edges
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_q <= 6'h00;
      tq_q <= 5'h00;
      ext_q <= 5'h00;
      o_sample <= 1'b0;
      o_rx_bit <= 1'b1;
    end else begin
      o_sample <= 1'b0;
      pre_q <= tq_en ? 6'h00 : pre_q + 6'h01;
      if (fall && i_bus_idle) begin
        pre_q <= 6'h00;
        tq_q <= 5'h01;
        ext_q <= 5'h00;
      end else if (fall && !i_tx_dominant && tq_q != 5'h00) begin
        if (tq_q <= s_pt) begin
          ext_q <= (tq_q < sjw_len) ? tq_q : sjw_len;
        end else if (left <= sjw_len) begin
          tq_q <= 5'h00;
          ext_q <= 5'h00;
        end
      end else if (tq_en) begin
        if (tq_q == s_pt) begin
          o_sample <= 1'b1;
          o_rx_bit <= s2_q;
        end
        if (tq_q >= e_pt) begin
          tq_q <= 5'h00;
          ext_q <= 5'h00;
        end else begin
          tq_q <= tq_q + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- cmof_top.v ----
// Functional notes
// - Standard frames filtered by 11-bit short mask
// - Extended frames filtered by 29-bit long mask
// - Mask bit zero means identifier bit ignored
// - Last object is receive only catch-all
// - Last object mask ANDed with format mask
// - Fifteen objects, eight data bytes, own control
// - Other objects choose transmit or receive
// - Transmit object auto-answers matching remote frame
// - Request on receive object sends remote frame
// - Per-object transmit and receive done flags
// - Join bus after eleven recessive bits
// - Interrupt register shows pending source
// - Bit timing register sets rate and segments
// - Everything fits one 256-byte region
// - Passive at 128, bus-off at 256
// - Warning flag while counter at least 96
// - Hard sync at frame start, resync otherwise
`include "cmof_defs.vh"
`default_nettype none
module cmof_top (
  input wire i_clock,
  input wire i_rstn,
  input wire [7:0] i_addr,
  input wire [15:0] i_wr_data,
  input wire i_wr_en,
  input wire i_rd_en,
  output wire [15:0] o_rd_data,
  input wire i_can_rx,
  input wire i_tx_bit,
  input wire i_bus_idle,
  output reg o_can_tx,
  output wire o_sample,
  output wire o_rx_bit,
  input wire i_rx_valid,
  input wire i_rx_ext,
  input wire i_rx_rtr,
  input wire [28:0] i_rx_id,
  input wire [3:0] i_rx_dlc,
  input wire [63:0] i_rx_data,
  output reg o_tx_valid,
  output reg [3:0] o_tx_obj,
  output reg o_tx_ext,
  output reg o_tx_rtr,
  output reg [28:0] o_tx_id,
  output reg [3:0] o_tx_dlc,
  output wire [63:0] o_tx_data,
  input wire i_tx_done,
  input wire [8:0] i_tec,
  input wire [8:0] i_rec,
  output reg o_joined,
  output reg o_error_warning_flag,
  output reg o_error_passive,
  output reg o_bus_off
);
  reg [15:0] ctrl_q;
  reg [14:0] btime_q;
  reg [10:0] gms_q;
  reg [28:0] gml_q, lmask_q;
  reg [4:0] int_q;
  reg [3:0] idle_q;
  reg busy_q, fetch_q;
  reg [15:0] rd_bypass;
  wire [15:0] rx_hit, rr_hit, txreq_v, rxdone_v, txdone_v;
  wire [15:0] ctrl_w [1:15];
  wire [28:0] id_w [1:15];
  wire cfg_on = ctrl_q[`CMOF_CTRL_SETUP] | ctrl_q[`CMOF_CTRL_CFG_CHANGE];
  wire cfg_write_ok = ctrl_q[`CMOF_CTRL_SETUP] & ctrl_q[`CMOF_CTRL_CFG_CHANGE];
  wire [3:0] a_obj = i_addr[7:4];
  wire [2:0] a_word = i_addr[3:1];
  wire rx_take = i_rx_valid & o_joined;
  wire [3:0] store_obj;
  wire store_en = rx_take & (|rx_hit);
  wire [3:0] tx_pick;
  wire tx_start = o_joined & ~busy_q & (|txreq_v);
  wire tx_end = busy_q & i_tx_done;
  wire [3:0] int_obj;
  wire [2:0] lane3 = a_word - `CMOF_OW_DATA0;
  wire use_mem = (a_obj != 4'h0) && (a_word >= `CMOF_OW_DATA0) && (a_word <= `CMOF_OW_DATA3);
  wire [63:0] mem_wdata = store_en ? i_rx_data : {4{i_wr_data}};
  wire [3:0] mem_lanes;
  wire [3:0] mem_obj = store_en ? store_obj : a_obj;
  assign rx_hit[0] = 1'b0;
  assign rr_hit[0] = 1'b0;
  assign txreq_v[0] = 1'b0;
  assign rxdone_v[0] = 1'b0;
  assign txdone_v[0] = 1'b0;
  // Received data wins the data store; a same-cycle bus data write is lost
  assign mem_lanes = store_en ? 4'hf :
    (i_wr_en && use_mem) ? (4'h1 << lane3[1:0]) : 4'h0;

  // Lowest set bit among objects 1..15
  function [3:0] lowest;
    input [15:0] v;
    integer i;
    begin
      lowest = 4'h0;
      for (i = 15; i >= 1; i = i - 1) begin
        if (v[i]) begin
          lowest = i[3:0];
        end
      end
    end
  endfunction

  assign store_obj = lowest(rx_hit);
  assign tx_pick = lowest(txreq_v);
  assign int_obj = lowest(rxdone_v | txdone_v);

  // Message objects: control, identifier, filter match
  genvar g;
  generate
    for (g = 1; g <= 15; g = g + 1) begin : g_obj
      localparam [3:0] OBJ = g;
      localparam IS_LAST = (g == 15);
      reg valid_q, dir_q, long_q, auto_q, txreq_q, rxdone_q, txdone_q;
      reg [3:0] dlc_q;
      reg [28:0] id_q;
      wire wr_ctrl = i_wr_en && a_obj == OBJ && a_word == `CMOF_OW_CTRL;
      wire wr_lo = i_wr_en && a_obj == OBJ && a_word == `CMOF_OW_ID_LO;
      wire wr_hi = i_wr_en && a_obj == OBJ && a_word == `CMOF_OW_ID_HI;
      wire [28:0] fmask = i_rx_ext ? gml_q : {18'h0, gms_q};
      wire [28:0] mask = IS_LAST ? (fmask & lmask_q) : fmask;
      wire id_ok = ((id_q ^ i_rx_id) & mask) == 29'h0;
      wire hit = valid_q & (long_q == i_rx_ext) & id_ok;
      wire store_me = store_en && store_obj == OBJ;
      wire done_me = tx_end && o_tx_obj == OBJ;
      wire rr_me = rx_take & rr_hit[g];
      assign rx_hit[g] = hit & ~dir_q & ~i_rx_rtr;
      assign rr_hit[g] = hit & dir_q & auto_q & i_rx_rtr;
      assign txreq_v[g] = txreq_q;
      assign rxdone_v[g] = rxdone_q;
      assign txdone_v[g] = txdone_q;
      assign id_w[g] = id_q;
      assign ctrl_w[g] = {4'h0, dlc_q, 1'b0, txdone_q, rxdone_q, txreq_q,
        auto_q, long_q, dir_q, valid_q};
      always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          valid_q <= 1'b0;
          dir_q <= 1'b0;
          long_q <= 1'b0;
          auto_q <= 1'b0;
          txreq_q <= 1'b0;
          rxdone_q <= 1'b0;
          txdone_q <= 1'b0;
          dlc_q <= 4'h0;
          id_q <= 29'h0;
        end else begin
          if (wr_ctrl) begin
            valid_q <= i_wr_data[`CMOF_OC_VALID];
            dir_q <= IS_LAST ? 1'b0 : i_wr_data[`CMOF_OC_DIR];
            long_q <= i_wr_data[`CMOF_OC_LONG];
            auto_q <= IS_LAST ? 1'b0 : i_wr_data[`CMOF_OC_AUTO];
            dlc_q <= i_wr_data[11:8];
          end
          if (wr_lo) begin
            id_q[15:0] <= i_wr_data;
          end
          if (wr_hi) begin
            id_q[28:16] <= i_wr_data[12:0];
          end
          // Transmit request: software sets, done clears, remote match sets
          if (IS_LAST) begin
            txreq_q <= 1'b0;
          end else if (rr_me) begin
            txreq_q <= 1'b1;
          end else if (done_me) begin
            txreq_q <= 1'b0;
          end else if (wr_ctrl) begin
            txreq_q <= i_wr_data[`CMOF_OC_TXREQ];
          end
          // Done flags: write one clears, hardware set wins
          rxdone_q <= (rxdone_q & ~(wr_ctrl & i_wr_data[`CMOF_OC_RXDONE])) | store_me;
          txdone_q <= (txdone_q & ~(wr_ctrl & i_wr_data[`CMOF_OC_TXDONE])) | done_me;
          if (store_me) begin
            id_q <= i_rx_id;
            dlc_q <= i_rx_dlc;
          end
        end
      end
    end
  endgenerate

  // Global registers; timing and global masks change only while setup and configuration-change bits are both set, last-object mask at any time
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= `CMOF_CTRL_RESET;
      btime_q <= 15'h0000;
      gms_q <= 11'h000;
      gml_q <= 29'h0;
      lmask_q <= 29'h0;
    end else if (i_wr_en) begin
      case (i_addr)
        `CMOF_OFS_CTRL: ctrl_q <= i_wr_data & 16'h0041;
        `CMOF_OFS_BTIME: if (cfg_write_ok) btime_q <= i_wr_data[14:0];
        `CMOF_OFS_GMS: if (cfg_write_ok) gms_q <= i_wr_data[10:0];
        `CMOF_OFS_GML_LO: if (cfg_write_ok) gml_q[15:0] <= i_wr_data;
        `CMOF_OFS_GML_HI: if (cfg_write_ok) gml_q[28:16] <= i_wr_data[12:0];
        `CMOF_OFS_LMASK_LO: lmask_q[15:0] <= i_wr_data;
        `CMOF_OFS_LMASK_HI: lmask_q[28:16] <= i_wr_data[12:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Register read value for non-memory words (whole map in 256 bytes)
  always @* begin
    rd_bypass = 16'h0000;
    if (a_obj != 4'h0) begin
      case (a_word)
        `CMOF_OW_CTRL: rd_bypass = ctrl_w[a_obj];
        `CMOF_OW_ID_LO: rd_bypass = id_w[a_obj][15:0];
        `CMOF_OW_ID_HI: rd_bypass = {3'h0, id_w[a_obj][28:16]};
        default: begin
          // Last-object mask high word lives in the spare word of object 15
          rd_bypass = (i_addr == `CMOF_OFS_LMASK_HI) ? {3'h0, lmask_q[28:16]} : 16'h0000;
        end
      endcase
    end else begin
      case (i_addr)
        `CMOF_OFS_CTRL: rd_bypass = ctrl_q;
        `CMOF_OFS_STAT: rd_bypass = {12'h000, o_joined, o_error_warning_flag,
          o_bus_off, o_error_passive};
        `CMOF_OFS_INT: rd_bypass = {11'h000, int_q};
        `CMOF_OFS_BTIME: rd_bypass = {1'b0, btime_q};
        `CMOF_OFS_GMS: rd_bypass = {5'h00, gms_q};
        `CMOF_OFS_GML_LO: rd_bypass = gml_q[15:0];
        `CMOF_OFS_GML_HI: rd_bypass = {3'h0, gml_q[28:16]};
        `CMOF_OFS_LMASK_LO: rd_bypass = lmask_q[15:0];
        default: rd_bypass = 16'h0000;
      endcase
    end
  end

  // Pending interrupt source: object number, bit 4 set for transmit
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      int_q <= 5'h00;
    end else if (int_obj == 4'h0) begin
      int_q <= 5'h00;
    end else begin
      int_q <= {~rxdone_v[int_obj], int_obj};
    end
  end

  // Error state from the protocol engine's counters
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_error_warning_flag <= 1'b0;
      o_error_passive <= 1'b0;
      o_bus_off <= 1'b0;
    end else begin
      o_error_warning_flag <= (i_tec >= `CMOF_WARN_LIMIT) | (i_rec >= `CMOF_WARN_LIMIT);
      o_error_passive <= (i_tec >= `CMOF_PASSIVE_LIMIT) | (i_rec >= `CMOF_PASSIVE_LIMIT);
      o_bus_off <= ({1'b0, i_tec} >= `CMOF_BUSOFF_LIMIT);
    end
  end

  // Bus join: count recessive samples after configuration ends
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      idle_q <= 4'h0;
      o_joined <= 1'b0;
    end else if (cfg_on) begin
      idle_q <= 4'h0;
      o_joined <= 1'b0;
    end else if (!o_joined && o_sample) begin
      if (!o_rx_bit) begin
        idle_q <= 4'h0;
      end else if (idle_q == `CMOF_IDLE_BITS - 4'h1) begin
        o_joined <= 1'b1;
      end else begin
        idle_q <= idle_q + 4'h1;
      end
    end
  end

  // Transmit scheduling: lowest requesting object, held until done
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
      fetch_q <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_obj <= 4'h0;
      o_tx_ext <= 1'b0;
      o_tx_rtr <= 1'b0;
      o_tx_id <= 29'h0;
      o_tx_dlc <= 4'h0;
    end else begin
      fetch_q <= tx_start;
      if (tx_start) begin
        busy_q <= 1'b1;
        o_tx_obj <= tx_pick;
      end
      if (fetch_q) begin
        o_tx_valid <= 1'b1;
        o_tx_id <= id_w[o_tx_obj];
        o_tx_ext <= ctrl_w[o_tx_obj][`CMOF_OC_LONG];
        o_tx_rtr <= ~ctrl_w[o_tx_obj][`CMOF_OC_DIR];
        o_tx_dlc <= ctrl_w[o_tx_obj][11:8];
      end
      if (tx_end) begin
        busy_q <= 1'b0;
        o_tx_valid <= 1'b0;
      end
    end
  end

  // Pin driver: recessive while not joined
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_can_tx <= 1'b1;
    end else begin
      o_can_tx <= o_joined ? i_tx_bit : 1'b1;
    end
  end

  cmof_mem #(
    .DEPTH(16)
  ) u_mem (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_wr_obj(mem_obj),
    .i_wr_lanes(mem_lanes),
    .i_wr_data(mem_wdata),
    .i_rd_en(i_rd_en),
    .i_rd_obj(a_obj),
    .i_rd_lane(lane3[1:0]),
    .i_rd_use_mem(use_mem),
    .i_rd_bypass(rd_bypass),
    .o_rd_data(o_rd_data),
    .i_tx_rd(tx_start),
    .i_tx_obj(tx_pick),
    .o_tx_data(o_tx_data)
  );

  cmof_btl u_btl (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_can_rx(i_can_rx),
    .i_brp(btime_q[5:0]),
    .i_tseg1(btime_q[9:6]),
    .i_tseg2(btime_q[12:10]),
    .i_sjw(btime_q[14:13]),
    .i_bus_idle(i_bus_idle),
    .i_tx_dominant(~o_can_tx),
    .o_rx_bit(o_rx_bit),
    .o_sample(o_sample)
  );
endmodule
`default_nettype wire

// ---- cmof_node.sv ----
`default_nettype none
// Far-side engine and bus pin model: delivers parsed frames, acknowledges sends
module cmof_node (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_tx_valid,
  output logic o_tx_done,
  output logic o_can_rx,
  output logic o_rx_valid,
  output logic o_rx_ext,
  output logic o_rx_rtr,
  output logic [28:0] o_rx_id,
  output logic [3:0] o_rx_dlc,
  output logic [63:0] o_rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rx_line = 1'b1;
  int wait_n = 0;
  int cnt;
  // Bus idles recessive; the bench may pull it dominant
  assign o_can_rx = rx_line;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_ext = 1'b0;
    o_rx_rtr = 1'b0;
    o_rx_id = 29'h0;
    o_rx_dlc = 4'h0;
    o_rx_data = 64'h0;
  end
  // One-cycle frame pulse; format, identifier and data scrambled afterwards so stale values never match
  task automatic send(input logic ext, input logic rtr, input logic [28:0] id,
                      input logic [3:0] dlc, input logic [63:0] data);
    @(posedge i_clock);
    o_rx_valid <= 1'b1;
    o_rx_ext <= ext;
    o_rx_rtr <= rtr;
    o_rx_id <= id;
    o_rx_dlc <= dlc;
    o_rx_data <= data;
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_ext <= ~ext;
    o_rx_id <= ~id;
    o_rx_data <= ~data;
  endtask
  // Acknowledge a pending send after wait_n cycles
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_done <= 1'b0;
      cnt <= 0;
    end else begin
      o_tx_done <= 1'b0;
      if (i_tx_valid && !o_tx_done) begin
        if (cnt >= wait_n) begin
          o_tx_done <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- cmof_top_sva.sv ----
`default_nettype none
// Port-level checks for the object filter
module cmof_top_chk (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_rd_en,
  input wire logic [15:0] o_rd_data,
  input wire logic i_tx_bit,
  input wire logic o_can_tx,
  input wire logic o_joined,
  input wire logic o_sample,
  input wire logic o_rx_bit,
  input wire logic [8:0] i_tec,
  input wire logic [8:0] i_rec,
  input wire logic o_error_warning_flag,
  input wire logic o_error_passive,
  input wire logic o_bus_off,
  input wire logic o_tx_valid,
  input wire logic i_tx_done,
  input wire logic [3:0] o_tx_obj,
  input wire logic [28:0] o_tx_id
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Pin recessive and join held back by a dominant sample
  property p_tx_idle;
    !o_joined && !$past(o_joined) |-> o_can_tx;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("pin driven before join");
  // Once joined the pin carries the engine bit one cycle later
  property p_tx_follow;
    $past(o_joined) |-> o_can_tx == $past(i_tx_bit);
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("pin not following engine");
  property p_dom_restart;
    o_sample && !o_rx_bit && !o_joined |=> !o_joined;
  endproperty
  a_dom_restart: assert property (p_dom_restart) else $error("joined after dominant");
  // Error state flags follow the counters one cycle later
  property p_warn;
    1'b1 |=> o_error_warning_flag == ($past(i_tec) >= 9'h060 || $past(i_rec) >= 9'h060);
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag wrong");
  property p_passive;
    (i_tec >= 9'h080 || i_rec >= 9'h080) |=> o_error_passive;
  endproperty
  a_passive: assert property (p_passive) else $error("passive flag missing");
  property p_busoff;
    1'b1 |=> o_bus_off == $past(i_tec[8]);
  endproperty
  a_busoff: assert property (p_busoff) else $error("bus-off flag wrong");
  // A send stands unchanged until acknowledged, then ends
  property p_tx_hold;
    o_tx_valid && !i_tx_done |=> o_tx_valid && $stable(o_tx_id) && $stable(o_tx_obj);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("send dropped early");
  property p_tx_end;
    o_tx_valid && i_tx_done |=> !o_tx_valid;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("send not ended");
  property p_tx_obj;
    o_tx_valid |-> o_tx_obj != 4'hf && o_tx_obj != 4'h0;
  endproperty
  a_tx_obj: assert property (p_tx_obj) else $error("illegal sending object");
  property p_rd_hold;
    !i_rd_en |=> $stable(o_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
endmodule
bind cmof_top cmof_top_chk u_chk (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .i_tx_bit(i_tx_bit), .o_can_tx(o_can_tx), .o_joined(o_joined), .o_sample(o_sample),
  .o_rx_bit(o_rx_bit),
  .i_tec(i_tec), .i_rec(i_rec), .o_error_warning_flag(o_error_warning_flag),
  .o_error_passive(o_error_passive), .o_bus_off(o_bus_off), .o_tx_valid(o_tx_valid),
  .i_tx_done(i_tx_done), .o_tx_obj(o_tx_obj), .o_tx_id(o_tx_id)
);
`default_nettype wire

// ---- can_message_object_filter_tb_top.sv ----
`include "cmof_defs.vh"
`default_nettype none
// Register-level bench for the object filter
module can_message_object_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [8:0] tec = 9'h000;
  logic [8:0] rec = 9'h000;
  logic tx_bit = 1'b1;
  wire [15:0] rd_data;
  wire can_rx, rx_valid, rx_ext, rx_rtr, tx_done, tx_valid, tx_ext, tx_rtr, joined;
  wire [28:0] rx_id, tx_id;
  wire [3:0] rx_dlc, tx_obj, tx_dlc;
  wire [63:0] rx_data, tx_data;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [8:0] tv [4] = '{9'h060, 9'h000, 9'h100, 9'h05f};
  logic [8:0] rv [4] = '{9'h000, 9'h080, 9'h000, 9'h05f};
  logic [15:0] ev [4] = '{16'h0004, 16'h0005, 16'h0007, 16'h0000};
  always #5 i_clock = ~i_clock;
  cmof_top dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .o_rd_data(rd_data), .i_can_rx(can_rx), .i_tx_bit(tx_bit),
    .i_bus_idle(1'b1), .o_can_tx(), .o_sample(), .o_rx_bit(), .i_rx_valid(rx_valid),
    .i_rx_ext(rx_ext), .i_rx_rtr(rx_rtr), .i_rx_id(rx_id), .i_rx_dlc(rx_dlc),
    .i_rx_data(rx_data), .o_tx_valid(tx_valid), .o_tx_obj(tx_obj), .o_tx_ext(tx_ext),
    .o_tx_rtr(tx_rtr), .o_tx_id(tx_id), .o_tx_dlc(tx_dlc), .o_tx_data(tx_data),
    .i_tx_done(tx_done), .i_tec(tec), .i_rec(rec), .o_joined(joined),
    .o_error_warning_flag(), .o_error_passive(), .o_bus_off()
  );
  cmof_node node (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_tx_valid(tx_valid), .o_tx_done(tx_done),
    .o_can_rx(can_rx), .o_rx_valid(rx_valid), .o_rx_ext(rx_ext), .o_rx_rtr(rx_rtr),
    .o_rx_id(rx_id), .o_rx_dlc(rx_dlc), .o_rx_data(rx_data)
  );
  // Verdict and end of run
  task automatic conclude;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge i_clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    @(posedge i_clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_clock);
    rd_en <= 1'b0;
    #1 chk(rd_data & m, e);
  endtask
  // Identifier words first, control word last
  task automatic obj(input int n, input logic [15:0] c, input logic [28:0] id);
    wr(8'(n * 16) + 8'h02, id[15:0]);
    wr(8'(n * 16) + 8'h04, {3'h0, id[28:16]});
    wr(8'(n * 16), c);
  endtask
  // Wait for a send, compare its fields, wait for its end
  task automatic tx_expect(input logic [3:0] o, input logic ext, input logic rtr,
                           input logic [28:0] id, input logic [3:0] dlc,
                           input logic [15:0] d, input logic dchk);
    repeat (40) if (tx_valid !== 1'b1) begin @(posedge i_clock); #1; end
    chk({tx_valid, tx_obj, tx_ext, tx_rtr, tx_dlc}, {1'b1, o, ext, rtr, dlc});
    chk(tx_id, id);
    if (dchk) chk(tx_data[15:0], d);
    repeat (40) if (tx_valid !== 1'b0) begin @(posedge i_clock); #1; end
  endtask
  // Hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    tx_bit <= ~tx_bit; // Engine bit stream stand-in
    if (cycles == 4000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(`CMOF_OFS_CTRL, 16'h0001);
    rd(`CMOF_OFS_INT, 16'h0000);
    rd(8'h1e, 16'h0000);
    wr(`CMOF_OFS_BTIME, 16'h0041);
    rd(`CMOF_OFS_BTIME, 16'h0000);
    wr(`CMOF_OFS_CTRL, 16'h0041);
    wr(`CMOF_OFS_BTIME, 16'h0040);
    rd(`CMOF_OFS_BTIME, 16'h0040);
    wr(`CMOF_OFS_GMS, 16'h07f0);
    wr(`CMOF_OFS_GML_LO, 16'hffff);
    wr(`CMOF_OFS_GML_HI, 16'h1fff);
    wr(`CMOF_OFS_LMASK_LO, 16'h0000);
    wr(`CMOF_OFS_LMASK_HI, 16'h0abc);
    rd(`CMOF_OFS_GMS, 16'h07f0);
    rd(`CMOF_OFS_GML_HI, 16'h1fff);
    for (int n = 5; n < 15; n++) wr(8'(n * 16), 16'h0000);
    obj(1, 16'h0001, 29'h120);
    obj(2, 16'h0001, 29'h120);
    obj(3, 16'h080f, 29'h1234567);
    obj(4, 16'h0001, 29'h300);
    obj(15, 16'h001b, 29'h0);
    wr(8'h36, 16'ha1b2);
    rd(8'hf0, 16'h0001);
    rd(`CMOF_OFS_LMASK_HI, 16'h0abc);
    // Leave configuration; a dominant burst restarts the idle count
    wr(`CMOF_OFS_CTRL, 16'h0000);
    node.rx_line <= 1'b0;
    repeat (20) @(posedge i_clock);
    node.rx_line <= 1'b1;
    repeat (32) @(posedge i_clock);
    rd(`CMOF_OFS_STAT, 16'h0000, 16'h0008);
    repeat (200) if (joined !== 1'b1) begin @(posedge i_clock); #1; end
    rd(`CMOF_OFS_STAT, 16'h0008, 16'h0008);
    // Standard frames: masked bits, lowest object, catch-all
    node.send(1'b0, 1'b0, 29'h12a, 4'h4, 64'h0000_0000_0000_5a5a);
    rd(8'h10, 16'h0421);
    rd(8'h20, 16'h0001);
    rd(8'h12, 16'h012a);
    rd(8'h16, 16'h5a5a);
    rd(`CMOF_OFS_INT, 16'h0001);
    node.send(1'b0, 1'b0, 29'h555, 4'h2, 64'h0);
    rd(8'hf0, 16'h0221);
    rd(8'h40, 16'h0001);
    // Remote frame answered automatically, prompt partner
    node.send(1'b1, 1'b1, 29'h1234567, 4'h0, 64'h0);
    tx_expect(4'h3, 1'b1, 1'b0, 29'h1234567, 4'h8, 16'ha1b2, 1'b1);
    rd(8'h30, 16'h084f);
    // Request on a receive object sends a remote frame, slow partner
    node.wait_n = 6;
    wr(8'h40, 16'h0011);
    tx_expect(4'h4, 1'b0, 1'b1, 29'h300, 4'h0, 16'h0000, 1'b0);
    rd(8'h40, 16'h0041);
    wr(8'h10, 16'h0021);
    rd(`CMOF_OFS_INT, 16'h0013);
    // Error counter thresholds
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      tec <= tv[k];
      rec <= rv[k];
      repeat (3) @(posedge i_clock);
      rd(`CMOF_OFS_STAT, ev[k], 16'h0007);
    end
    conclude();
  end
endmodule
`default_nettype wire
